// ===== hdl/asmp_abort_status_and_master_priority.sv
// abort status recorder, per-master priority arbiter and wishbone register slave
`timescale 1ns/100ps
module asmp_abort_status_and_master_priority
(
    input wire logic clk, // system clock, 250 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic ce, // clock enable, freezes all state while low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [31:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic [asmp_pkg::ASMP_MASTERS-1:0] req, // per-master bus request
    output logic [asmp_pkg::ASMP_MASTERS-1:0] grant, // one-hot bus grant
    input wire logic acc_valid, // granted master presents an access
    input wire logic [31:0] acc_addr, // access address
    input wire logic [1:0] acc_size, // access size code
    input wire logic [1:0] acc_type, // access type code
    input wire logic acc_unmapped, // address decoder found no target
    output logic acc_cancel, // access cancelled, one-cycle pulse
    output logic abort_out // abort broadcast to all masters, one-cycle pulse
);
    import asmp_pkg::*;

    localparam int ASMP_PRIO_LANES = 2; // byte lanes that hold priority fields

    // timing overview
    // - an access is judged in the cycle it is presented
    // - the presenting master is the one holding the grant
    // - abort and cancel pulses follow one edge later, for one cycle
    // - status and address load on that same edge, never apart
    // - a wishbone request is acked one edge after it is taken
    // - the acked cycle is never taken a second time
    // - read data is registered and holds until the next read
    // - a status read clears history on the edge it is taken
    // - an abort on that same edge still lands in history
    // - grant is re-arbitrated on every enabled edge
    // - with ce low every flop keeps its value
    // hazards
    // - a requester that drops out loses the grant on the next edge
    // - byte lanes two and three of the priority word are not writable
    // - writes to the read-only registers are acked and ignored
    // - an unmapped cause hides a misaligned cause of the same access
    // - the reserved size code is never checked for alignment
    // - processor fetches are never checked for alignment
    // - the history keeps no count, only whether an abort happened

    // the status layout has exactly four source and four history bits
    if (ASMP_MASTERS != 4)
    begin : g_chk_masters
        $error("master count does not fit the status layout");
    end
    // a priority field must fit inside its nibble
    if (ASMP_PRIO_W > ASMP_PRIO_STRIDE)
    begin : g_chk_prio_width
        $error("priority field wider than its stride");
    end
    // the source and history fields must not overlap
    if (ASMP_POS_SRC + ASMP_MASTERS > ASMP_POS_SAVED)
    begin : g_chk_src_span
        $error("source flags run into the history flags");
    end
    // the history field must end inside the status word
    if (ASMP_POS_SAVED + ASMP_MASTERS > 32)
    begin : g_chk_saved_span
        $error("history flags run past the status word");
    end
    // the priority fields must fit inside the writable byte lanes
    if (ASMP_MASTERS * ASMP_PRIO_STRIDE > 8 * ASMP_PRIO_LANES)
    begin : g_chk_lanes
        $error("priority fields run past the writable lanes");
    end

    // status fields
    logic unmapped_addr_flag; // last abort hit an unmapped address
    logic misaligned_flag; // last abort was misaligned
    logic [1:0] abort_size; // size of last aborted access
    logic [1:0] abort_type; // type of last aborted access
    logic [ASMP_MASTERS-1:0] src_flag; // current abort source
    logic [ASMP_MASTERS-1:0] saved_flag; // sticky abort history
    logic [31:0] abort_addr_value; // address of last aborted access
    // arbitration state
    logic [31:0] master_priority; // priority register
    logic [ASMP_MASTERS-1:0] owner; // master currently granted, one-hot
    // access decode
    logic misaligned; // current access misaligned
    logic abort_now; // current access aborts
    logic [31:0] abort_status; // assembled status word
    // register bus decode
    logic bus_req; // wishbone request pending and not yet acked
    logic status_read; // status register read accepted this cycle
    logic [ASMP_MASTERS-1:0] next_grant; // arbitration result
    logic [ASMP_PRIO_W-1:0] prio_field [ASMP_MASTERS]; // per-master priority
    logic [7:0] prio_lane [ASMP_PRIO_LANES]; // writable priority byte lanes
    logic prio_write; // priority register write accepted this cycle
    logic check_align; // access is subject to the alignment check
    logic size_word; // access size decodes as word
    logic size_half; // access size decodes as half-word
    logic cpu_fetch; // processor instruction fetch
    logic [31:0] read_word; // register selected for readback
    // named per-master flags
    logic src_cpu_flag; // last abort from the processor
    logic src_dma_flag; // last abort from the peripheral dma
    logic src_usbhost_flag; // last abort from the usb host
    logic src_mac_flag; // last abort from the ethernet mac
    logic saved_cpu_flag; // earlier processor abort
    logic saved_dma_flag; // earlier peripheral dma abort
    logic saved_usbhost_flag; // earlier usb host abort
    logic saved_mac_flag; // earlier ethernet mac abort

    // the master presenting an access is the one holding the grant
    assign owner = grant;

    // size decode; the reserved size code never counts as misaligned
    assign size_word = (acc_size == ASMP_SIZE_WORD);
    assign size_half = (acc_size == ASMP_SIZE_HALF);
    // processor fetches bypass the alignment check
    assign cpu_fetch = owner[0] && acc_type == ASMP_TYPE_FETCH;
    assign check_align = !cpu_fetch;

    // alignment check on the presented access
    // byte accesses are always aligned
    always_comb
    begin
        misaligned = 1'b0;
        if (check_align)
        begin
            if (size_word)
            begin
                misaligned = (acc_addr[1:0] != 2'h0);
            end
            else if (size_half)
            begin
                misaligned = acc_addr[0];
            end
        end
    end

    // abort on either cause; the aborted access goes nowhere
    assign abort_now = acc_valid && (misaligned || acc_unmapped);

    // abort broadcast and cancel pulses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // pulses idle low out of reset
            abort_out <= 1'b0;
            acc_cancel <= 1'b0;
        end
        else if (ce)
        begin
            // one pulse per faulty access, seen by all masters
            abort_out <= abort_now;
            acc_cancel <= abort_now;
        end
    end

    // capture of cause, size, type, source and address in one edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // status and address clear to zero
            unmapped_addr_flag <= 1'b0;
            misaligned_flag <= 1'b0;
            abort_size <= ASMP_SIZE_BYTE;
            abort_type <= ASMP_TYPE_READ;
            src_flag <= '0;
            abort_addr_value <= ASMP_RST_ABORT_ADDRESS;
        end
        else if (ce && abort_now)
        begin
            // an unmapped target takes precedence over misalignment
            unmapped_addr_flag <= acc_unmapped;
            misaligned_flag <= misaligned && !acc_unmapped;
            abort_size <= acc_size;
            abort_type <= acc_type;
            // exactly one source flag, that of the grant holder
            src_flag <= owner;
            // whole address, no bits dropped
            abort_addr_value <= acc_addr;
        end
    end

    // sticky history: a displaced current source moves into history
    // the new owner's bit stays clear, it shows in the source flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            saved_flag <= '0;
        end
        else if (ce)
        begin
            if (abort_now)
            begin
                // set wins over the read clear
                saved_flag <= ((status_read ? '0 : saved_flag) | src_flag) & ~owner;
            end
            else if (status_read)
            begin
                // the read cleared history and no new abort arrived
                saved_flag <= '0;
            end
        end
    end

    // priority write strobe, decoded once for all lanes
    assign prio_write = ce && bus_req && wb_we_i && wb_adr_i == ASMP_OFS_MASTER_PRIORITY;

    // priority register, one flop group per writable byte lane
    for (genvar gl = 0; gl < ASMP_PRIO_LANES; gl++)
    begin : g_lane
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                // default ranking puts the ethernet mac highest and the processor lowest
                prio_lane[gl] <= ASMP_RST_MASTER_PRIORITY[gl*8 +: 8];
            end
            else if (prio_write && wb_sel_i[gl])
            begin
                // three bits of each nibble hold state, the fourth reads zero
                prio_lane[gl] <= wb_dat_i[gl*8 +: 8] & ASMP_PRIO_MASK[gl*8 +: 8];
            end
        end
    end

    // upper lanes hold no priority and read zero
    assign master_priority = {16'h0000, prio_lane[1], prio_lane[0]};

    // per-master priority fields, one slice per master
    for (genvar gm = 0; gm < ASMP_MASTERS; gm++)
    begin : g_prio
        assign prio_field[gm] = master_priority[gm*ASMP_PRIO_STRIDE +: ASMP_PRIO_W];
    end

    // arbitration: highest priority wins, ties go to lower index
    always_comb
    begin
        logic [ASMP_PRIO_W-1:0] best;
        logic found;
        best = '0;
        found = 1'b0;
        next_grant = '0;
        for (int m = 0; m < ASMP_MASTERS; m++)
        begin
            // strict greater-than keeps the lower index on a tie
            if (req[m] && (!found ||
                prio_field[m] > best))
            begin
                best = prio_field[m];
                found = 1'b1;
                next_grant = '0;
                next_grant[m] = 1'b1;
            end
        end
    end

    // grant register, re-arbitrated every cycle with ce high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // nobody owns the bus out of reset
            grant <= '0;
        end
        else if (ce)
        begin
            // grant drops to zero when nobody asks
            grant <= next_grant;
        end
    end

    // named views of the per-master flags
    assign src_cpu_flag = src_flag[0];
    assign src_dma_flag = src_flag[1];
    assign src_usbhost_flag = src_flag[2];
    assign src_mac_flag = src_flag[3];
    assign saved_cpu_flag = saved_flag[0];
    assign saved_dma_flag = saved_flag[1];
    assign saved_usbhost_flag = saved_flag[2];
    assign saved_mac_flag = saved_flag[3];

    // status word assembly
    always_comb
    begin
        // unused bits read zero
        abort_status = ASMP_RST_ABORT_STATUS;
        abort_status[ASMP_BIT_UNMAPPED] = unmapped_addr_flag;
        abort_status[ASMP_BIT_MISALIGNED] = misaligned_flag;
        abort_status[ASMP_POS_SIZE +: 2] = abort_size;
        abort_status[ASMP_POS_TYPE +: 2] = abort_type;
        // one source flag per master
        abort_status[ASMP_POS_SRC + 0] = src_cpu_flag;
        abort_status[ASMP_POS_SRC + 1] = src_dma_flag;
        abort_status[ASMP_POS_SRC + 2] = src_usbhost_flag;
        abort_status[ASMP_POS_SRC + 3] = src_mac_flag;
        // one history flag per master
        abort_status[ASMP_POS_SAVED + 0] = saved_cpu_flag;
        abort_status[ASMP_POS_SAVED + 1] = saved_dma_flag;
        abort_status[ASMP_POS_SAVED + 2] = saved_usbhost_flag;
        abort_status[ASMP_POS_SAVED + 3] = saved_mac_flag;
    end

    // a request is served once; the acked cycle is not taken again
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // only an accepted read of the status register clears history
    assign status_read = ce && bus_req && !wb_we_i && wb_adr_i == ASMP_OFS_ABORT_STATUS;

    // read data mux; unmapped addresses read zero
    always_comb
    begin
        read_word = ASMP_UNMAPPED_READ;
        case (wb_adr_i)
            ASMP_OFS_ABORT_STATUS: read_word = abort_status;
            ASMP_OFS_ABORT_ADDRESS: read_word = abort_addr_value;
            ASMP_OFS_MASTER_PRIORITY: read_word = master_priority;
            default: read_word = ASMP_UNMAPPED_READ; // nothing mapped here
        endcase
    end

    // wishbone slave: ack one cycle after request, read data registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // bus idle out of reset
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else if (ce)
        begin
            // ack follows every accepted request by one edge
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                wb_dat_o <= read_word; // holds until the next read
            end
        end
    end
endmodule

// ===== hdl/asmp_pkg.sv
// constants for the abort status and master priority block
// What this block does
// - bit 0 flags unmapped-address abort
// - bit 1 flags misaligned-address abort
// - size field: byte, half, word codes
// - type field: read, write, fetch codes
// - bits 16-19 show last abort source
// - bits 24-27 sticky per-master abort history
// - history excludes current source; read clears it
// - full abort address captured, resets zero
// - 3-bit priority per master, 7 highest
// - equal priority: lower master index wins
// - misaligned word/half accesses abort, cancel
// - processor instruction fetches skip alignment check
// - abort broadcast; only issuing master reacts
package asmp_pkg;
    localparam int ASMP_MASTERS = 4;
    localparam logic [31:0] ASMP_OFS_ABORT_STATUS = 32'hFFFFFF04;
    localparam logic [31:0] ASMP_OFS_ABORT_ADDRESS = 32'hFFFFFF08;
    localparam logic [31:0] ASMP_OFS_MASTER_PRIORITY = 32'hFFFFFF0C;
    localparam logic [31:0] ASMP_RST_ABORT_STATUS = 32'h00000000;
    localparam logic [31:0] ASMP_RST_ABORT_ADDRESS = 32'h00000000;
    localparam logic [31:0] ASMP_RST_MASTER_PRIORITY = 32'h00003210;
    localparam int ASMP_BIT_UNMAPPED = 0;
    localparam int ASMP_BIT_MISALIGNED = 1;
    localparam int ASMP_POS_SIZE = 8;
    localparam int ASMP_POS_TYPE = 10;
    localparam int ASMP_POS_SRC = 16;
    localparam int ASMP_POS_SAVED = 24;
    localparam int ASMP_PRIO_STRIDE = 4;
    localparam int ASMP_PRIO_W = 3;
    localparam logic [31:0] ASMP_PRIO_MASK = 32'h00007777;
    localparam logic [1:0] ASMP_SIZE_BYTE = 2'h0;
    localparam logic [1:0] ASMP_SIZE_HALF = 2'h1;
    localparam logic [1:0] ASMP_SIZE_WORD = 2'h2;
    localparam logic [1:0] ASMP_TYPE_READ = 2'h0;
    localparam logic [1:0] ASMP_TYPE_WRITE = 2'h1;
    localparam logic [1:0] ASMP_TYPE_FETCH = 2'h2;
    localparam logic [31:0] ASMP_UNMAPPED_READ = 32'h00000000;
endpackage

// ===== test/asmp_abort_status_and_master_priority_test.sv
// self-checking bench for the abort status and master priority block
`timescale 1ns/100ps
module asmp_abort_status_and_master_priority_test;
    import asmp_pkg::*;
    typedef struct {logic [1:0] m, sz, ty; logic un; logic [31:0] a;} asmp_row_s;
    logic clk, rst_n, cyc, stb, we, av, un, ack, ab, cn, en;
    logic [31:0] adr, dat, q, aa, st, ad, rd;
    logic [3:0] want, req, grant, hit;
    logic [1:0] sz, ty;
    int n_mismatch = 0;
    int n_compared = 0;
    asmp_row_s rows[6] = '{'{2'h1, 2'h2, 2'h0, 1'b0, 32'h10000002},
        '{2'h2, 2'h1, 2'h1, 1'b0, 32'h10000001}, '{2'h3, 2'h0, 2'h1, 1'b1, 32'h00000020},
        '{2'h0, 2'h2, 2'h2, 1'b0, 32'h10000003}, '{2'h0, 2'h2, 2'h0, 1'b0, 32'h10000003},
        '{2'h1, 2'h2, 2'h0, 1'b0, 32'h10000004}};
    asmp_abort_status_and_master_priority i_dut (.clk(clk), .rst_n(rst_n), .ce(en),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .req(req), .grant(grant),
        .acc_valid(av), .acc_addr(aa), .acc_size(sz), .acc_type(ty), .acc_unmapped(un),
        .acc_cancel(cn), .abort_out(ab));
    asmp_masters i_masters (.clk(clk), .rst_n(rst_n), .want(want), .grant(grant),
        .acc_valid(av), .abort_out(ab), .req(req), .hit(hit));
    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string w, input logic [31:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", w, e, s);
            n_mismatch++;
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one wishbone cycle, then a gap cycle
    task automatic wb(input logic w, input logic [31:0] a, d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = q;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            n_mismatch++;
            give_verdict();
        end
        @(posedge clk);
    endtask
    // one access by a granted master, then status and address readback
    task automatic acc(input asmp_row_s r);
        logic mis, abt;
        logic [3:0] s;
        int n;
        s = 4'h1 << r.m;
        mis = ((r.sz == ASMP_SIZE_WORD && r.a[1:0] != 2'h0)
            || (r.sz == ASMP_SIZE_HALF && r.a[0])) && !(r.m == 2'h0 && r.ty == ASMP_TYPE_FETCH);
        abt = mis | r.un;
        want <= s;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (grant !== s && n < 20);
        chk("grant", grant, s);
        av <= 1'b1;
        aa <= r.a;
        sz <= r.sz;
        ty <= r.ty;
        un <= r.un;
        @(posedge clk);
        av <= 1'b0;
        want <= 4'h0;
        @(posedge clk);
        chk("abort", ab, abt);
        chk("owner", hit, abt ? s : 4'h0);
        chk("cancel", cn, abt);
        if (abt)
        begin
            st = {4'h0, (st[27:24] | st[19:16]) & ~s, 4'h0, s, 4'h0, r.ty, r.sz, 6'h0,
                mis & !r.un, r.un};
            ad = r.a;
        end
        wb(1'b0, ASMP_OFS_ABORT_STATUS, 32'h0);
        chk("status", rd, st);
        st[27:24] = 4'h0;
        wb(1'b0, ASMP_OFS_ABORT_ADDRESS, 32'h0);
        chk("address", rd, ad);
    endtask
    // table first, then reset values, read-only places and arbitration
    initial
    begin
        {rst_n, cyc, stb, we, av, un, adr, dat, aa, sz, ty, want, st, ad} = '0;
        en = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i])
            acc(rows[i]);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, ASMP_OFS_ABORT_STATUS, 32'h0);
        chk("status rst", rd, ASMP_RST_ABORT_STATUS);
        wb(1'b1, ASMP_OFS_ABORT_ADDRESS, 32'hFFFFFFFF);
        wb(1'b0, ASMP_OFS_ABORT_ADDRESS, 32'h0);
        chk("address rst", rd, ASMP_RST_ABORT_ADDRESS);
        wb(1'b0, ASMP_OFS_MASTER_PRIORITY, 32'h0);
        chk("prio rst", rd, ASMP_RST_MASTER_PRIORITY);
        wb(1'b0, 32'hFFFFFF10, 32'h0);
        chk("unmapped", rd, ASMP_UNMAPPED_READ);
        wb(1'b1, ASMP_OFS_MASTER_PRIORITY, 32'hFFFFFFFF);
        wb(1'b0, ASMP_OFS_MASTER_PRIORITY, 32'h0);
        chk("prio mask", rd, ASMP_PRIO_MASK);
        wb(1'b1, ASMP_OFS_MASTER_PRIORITY, 32'h00005555);
        want <= 4'hF;
        repeat (3) @(posedge clk);
        chk("tie", grant, 4'h1);
        wb(1'b1, ASMP_OFS_MASTER_PRIORITY, 32'h00000700);
        repeat (3) @(posedge clk);
        chk("highest", grant, 4'h4);
        // clock enable low freezes the grant register
        en <= 1'b0;
        want <= 4'h1;
        repeat (3) @(posedge clk);
        chk("frozen", grant, 4'h4);
        en <= 1'b1;
        repeat (2) @(posedge clk);
        chk("thawed", grant, 4'h1);
        give_verdict();
    end
endmodule

// ===== test/asmp_asserts.sv
// concurrent checks on the abort and priority block ports
`timescale 1ns/100ps
module asmp_asserts
(
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic ce, // enable
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic [3:0] req, // requests
    input wire logic [3:0] grant, // grant
    input wire logic acc_valid, // access
    input wire logic [31:0] acc_addr, // address
    input wire logic [1:0] acc_size, // size
    input wire logic [1:0] acc_type, // type
    input wire logic acc_unmapped, // no target
    input wire logic acc_cancel, // cancel
    input wire logic abort_out // abort
);
    import asmp_pkg::*;
    logic go; // access taken this edge
    logic mis; // misaligned word or half
    logic fx; // processor fetch
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign go = acc_valid & ce;
    assign fx = grant[0] & (acc_type == ASMP_TYPE_FETCH);
    assign mis = (acc_size == ASMP_SIZE_WORD && acc_addr[1:0] != 2'h0)
        || (acc_size == ASMP_SIZE_HALF && acc_addr[0]);
    chk_misalign_abort: assert property (go & mis & !fx |=> abort_out & acc_cancel)
        else $error("misaligned access not aborted");
    chk_fetch_exempt: assert property (go & fx & !acc_unmapped |=> !abort_out)
        else $error("processor fetch aborted");
    chk_unmapped_abort: assert property (go & acc_unmapped |=> abort_out)
        else $error("unmapped access not aborted");
    chk_clean_quiet: assert property (go & !acc_unmapped & !mis |=> !abort_out)
        else $error("clean access aborted");
    chk_abort_cause: assert property (abort_out |-> $past(go))
        else $error("abort without access");
    chk_cancel_abort: assert property (acc_cancel |-> abort_out)
        else $error("cancel without abort");
    chk_grant_onehot: assert property ($onehot0(grant))
        else $error("grant not one-hot");
    chk_grant_req: assert property (ce |=> (grant & ~$past(req)) == 4'h0)
        else $error("grant to idle master");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
    chk_ack_answer: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o & ce |=> wb_ack_o)
        else $error("request not acked");
    cover property (go & mis);
    cover property (go & acc_unmapped);
    cover property (grant[2]);
endmodule
bind asmp_abort_status_and_master_priority asmp_asserts i_chk (.clk, .rst_n, .ce,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req, .grant, .acc_valid, .acc_addr, .acc_size,
    .acc_type, .acc_unmapped, .acc_cancel, .abort_out);

// ===== test/asmp_masters.sv
// bus master models: request lines and abort reaction
`timescale 1ns/100ps
module asmp_masters
(
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic [3:0] want, // masters wanting the bus
    input wire logic [3:0] grant, // arbiter grant
    input wire logic acc_valid, // access presented
    input wire logic abort_out, // abort broadcast
    output logic [3:0] req, // request lines
    output logic [3:0] hit // master acting on the abort
);
    logic [3:0] issued; // issuer of the last access
    // a master asks for exactly as long as its want line is high
    assign req = want;
    // remember who issued, the abort answers one cycle later
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            issued <= 4'h0;
        else
            issued <= grant & {4{acc_valid}};
    end
    assign hit = issued & {4{abort_out}}; // others ignore it
endmodule
